// >>> afc_defs.svh
// What this block does
// - Any of eight channels may feed positive input, another the negative.
// - Channel select all ones connects the temperature diode, opens all channels.
// - Diode mode routes current source one to anode and pin, cathode grounded.
// - Open-sensor bit sources current on positive, sinks on negative input.
// - Input buffer is on only when buffer pin AND buffer bit are set.
// - Two current sources, each with 8-bit code and power-of-two range field.
// - Gain field selects one of eight gains from 1 to 128.
// - Offset trim is sign-magnitude: bit 7 sign, low seven bits magnitude.
// - Modulator clock is oscillator over 128, or over 256 when speed bit set.
// - Reference enable bit turns reference on; level bit picks 1.25V or 2.5V.
// - Three self calibrations: offset and gain, gain only, offset only.
// - Single calibration takes seven data periods; combined takes fourteen.
// - System offset and system gain calibrations take seven data periods each.
// - Data ready goes low when any calibration completes.
// - Filter is fast settling, second-order sinc, third-order sinc or automatic.
// - Automatic mode steps fast, sinc2, then sinc3 after channel or gain change.
// - Data ready goes low on a new result, high after data register read.
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH

// Register offsets on the byte register port.
`define AFC_OFS_SETUP 4'h0
`define AFC_OFS_MUX 4'h1
`define AFC_OFS_CTL 4'h2
`define AFC_OFS_SRC1 4'h3
`define AFC_OFS_SRC2 4'h4
`define AFC_OFS_TRIM 4'h5
`define AFC_OFS_DECLO 4'h8
`define AFC_OFS_DECHI 4'h9
`define AFC_OFS_STATUS 4'hb

// Reset values.
`define AFC_RST_SETUP 8'h00
`define AFC_RST_MUX 8'h01
`define AFC_RST_CTL 8'h00
`define AFC_RST_SRC 8'h00
`define AFC_RST_TRIM 8'h00
`define AFC_RST_DECLO 8'h80
`define AFC_RST_DECHI 8'h01

// Field positions.
`define AFC_SETUP_SPEED 4
`define AFC_SETUP_REFEN 3
`define AFC_SETUP_REFHI 2
`define AFC_SETUP_BUFEN 1
`define AFC_MUX_PSEL_LO 4
`define AFC_CTL_BURN 7
`define AFC_CTL_R2_LO 5
`define AFC_CTL_R1_LO 3
`define AFC_TRIM_SIGN 7
`define AFC_DECHI_FLT_LO 4
`define AFC_TEMP_CODE 8'hff

// Timing counts.
`define AFC_CAL_SINGLE 4'd7
`define AFC_CAL_BOTH 4'd14
`define AFC_DIV_FAST 9'd128
`define AFC_DIV_SLOW 9'd256

`endif

// >>> afc_frontend.sv
`timescale 1ns/1ps
`include "afc_defs.svh"
module afc_frontend #(
  parameter logic [2:0] ID_CODE = 3'h0 // Arbitrary identity value.
) (
  input wire logic clk,
  input wire logic rst_b,
  input afc_pkg::afc_reg_req_s regReq,
  output logic [7:0] regRdata,
  input wire logic bufferPin,
  input wire logic calCmdValid,
  input afc_pkg::afc_cmd_e calCmd,
  input wire logic dataReadDone,
  output afc_pkg::afc_analog_s analog,
  output logic modulatorClock,
  output afc_pkg::afc_filter_e filterSel,
  output logic calBusy,
  output afc_pkg::afc_cmd_e calKind,
  output logic dataReadyN
);

  logic [7:0] setup_r, mux_r, ctl_r, src1_r, src2_r, trim_r;
  logic [7:0] decLo_r, decHi_r;
  logic [7:0] setup_nxt, mux_nxt, ctl_nxt, src1_nxt, src2_nxt, trim_nxt;
  logic [7:0] decLo_nxt, decHi_nxt, rdata_nxt;
  logic settleRestart;
  logic bufMeta_r, bufSync_r;
  afc_pkg::afc_analog_s analog_nxt;
  logic [7:0] chanP, chanN;
  logic [10:0] dataCnt_r, dataCnt_nxt;
  logic dataTick_r, dataTick_nxt;
  afc_pkg::afc_cal_state_e calState_r, calState_nxt;
  logic [3:0] calCnt_r, calCnt_nxt, calTarget_r, calTarget_nxt;
  afc_pkg::afc_cmd_e calKind_nxt;
  logic readyN_nxt;
  logic [1:0] convIdx_r, convIdx_nxt;
  afc_pkg::afc_filter_e filter_nxt;
  afc_pkg::afc_filter_e fltMode;
  logic [10:0] decVal;

  assign fltMode = afc_pkg::afc_filter_e'(decHi_r[`AFC_DECHI_FLT_LO +: 2]);
  assign decVal = {decHi_r[2:0], decLo_r};

  // Register writes; a new channel or gain restarts filter settling.
  always_comb begin
    setup_nxt = setup_r;
    mux_nxt = mux_r;
    ctl_nxt = ctl_r;
    src1_nxt = src1_r;
    src2_nxt = src2_r;
    trim_nxt = trim_r;
    decLo_nxt = decLo_r;
    decHi_nxt = decHi_r;
    settleRestart = 1'b0;
    rdata_nxt = regRdata;
    if (regReq.wr) begin
      unique case (regReq.addr)
        `AFC_OFS_SETUP: setup_nxt = {3'h0, regReq.wdata[4:0]};
        `AFC_OFS_MUX: begin
          mux_nxt = regReq.wdata;
          settleRestart = regReq.wdata != mux_r;
        end
        `AFC_OFS_CTL: begin
          ctl_nxt = regReq.wdata;
          settleRestart = regReq.wdata[2:0] != ctl_r[2:0];
        end
        `AFC_OFS_SRC1: src1_nxt = regReq.wdata;
        `AFC_OFS_SRC2: src2_nxt = regReq.wdata;
        `AFC_OFS_TRIM: trim_nxt = regReq.wdata;
        `AFC_OFS_DECLO: decLo_nxt = regReq.wdata;
        `AFC_OFS_DECHI: decHi_nxt = {2'h0, regReq.wdata[5:4], 1'b0,
                                     regReq.wdata[2:0]};
        default: ;
      endcase
    end
    // Unmapped offsets read as zero; the identity field is read-only.
    if (regReq.rd) begin
      unique case (regReq.addr)
        `AFC_OFS_SETUP: rdata_nxt = {ID_CODE, setup_r[4:0]};
        `AFC_OFS_MUX: rdata_nxt = mux_r;
        `AFC_OFS_CTL: rdata_nxt = ctl_r;
        `AFC_OFS_SRC1: rdata_nxt = src1_r;
        `AFC_OFS_SRC2: rdata_nxt = src2_r;
        `AFC_OFS_TRIM: rdata_nxt = trim_r;
        `AFC_OFS_DECLO: rdata_nxt = decLo_r;
        `AFC_OFS_DECHI: rdata_nxt = decHi_r;
        `AFC_OFS_STATUS: rdata_nxt = {3'h0, filterSel, calBusy,
                                      calKind == afc_pkg::CMD_SELFCAL,
                                      dataReadyN};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      setup_r <= `AFC_RST_SETUP;
      mux_r <= `AFC_RST_MUX;
      ctl_r <= `AFC_RST_CTL;
      src1_r <= `AFC_RST_SRC;
      src2_r <= `AFC_RST_SRC;
      trim_r <= `AFC_RST_TRIM;
      decLo_r <= `AFC_RST_DECLO;
      decHi_r <= `AFC_RST_DECHI;
      regRdata <= 8'h00;
    end else begin
      setup_r <= setup_nxt;
      mux_r <= mux_nxt;
      ctl_r <= ctl_nxt;
      src1_r <= src1_nxt;
      src2_r <= src2_nxt;
      trim_r <= trim_nxt;
      decLo_r <= decLo_nxt;
      decHi_r <= decHi_nxt;
      regRdata <= rdata_nxt;
    end
  end

  // The buffer pin is asynchronous to the oscillator, so it is synchronised.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bufMeta_r <= 1'b0;
      bufSync_r <= 1'b0;
    end else begin
      bufMeta_r <= bufferPin;
      bufSync_r <= bufMeta_r;
    end
  end

  // Per-channel decode of the positive and negative selector fields.
  for (genvar ch = 0; ch < 8; ch++) begin : g_chan
    assign chanP[ch] = mux_r[`AFC_MUX_PSEL_LO +: 4] == 4'(ch);
    assign chanN[ch] = mux_r[3:0] == 4'(ch);
  end

  // Analog controls; codes 8 to 14 select no channel and leave inputs open.
  always_comb begin
    logic tempMode;
    tempMode = mux_r == `AFC_TEMP_CODE;
    analog_nxt.posSel = tempMode ? 8'h00 : chanP;
    analog_nxt.negSel = tempMode ? 8'h00 : chanN;
    analog_nxt.tempDiode = tempMode;
    analog_nxt.src1Anode = tempMode;
    analog_nxt.cathodeGnd = tempMode;
    analog_nxt.src1Pin = tempMode || ctl_r[`AFC_CTL_R1_LO +: 2] != 2'h0;
    analog_nxt.burnSrc = analog_nxt.posSel & {8{ctl_r[`AFC_CTL_BURN]}};
    analog_nxt.burnSink = analog_nxt.negSel & {8{ctl_r[`AFC_CTL_BURN]}};
    analog_nxt.bufferOn = bufSync_r && setup_r[`AFC_SETUP_BUFEN];
    analog_nxt.src1Code = src1_r;
    analog_nxt.src1Range = ctl_r[`AFC_CTL_R1_LO +: 2];
    analog_nxt.src2Code = src2_r;
    analog_nxt.src2Range = ctl_r[`AFC_CTL_R2_LO +: 2];
    analog_nxt.pgaSel = ctl_r[2:0];
    analog_nxt.offsetNeg = trim_r[`AFC_TRIM_SIGN];
    analog_nxt.offsetMag = trim_r[6:0];
    analog_nxt.refOn = setup_r[`AFC_SETUP_REFEN];
    analog_nxt.refHigh = setup_r[`AFC_SETUP_REFHI];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      analog <= '0;
    end else begin
      analog <= analog_nxt;
    end
  end

  afc_mod_clock u_mod_clock (
    .clk(clk),
    .rst_b(rst_b),
    .speedSlow(setup_r[`AFC_SETUP_SPEED]),
    .modTick(modulatorClock)
  );

  // Output-data period: decimation count of modulator ticks, zero as one.
  always_comb begin
    dataTick_nxt = 1'b0;
    dataCnt_nxt = dataCnt_r;
    if (modulatorClock) begin
      if (dataCnt_r + 11'd1 >= decVal) begin
        dataCnt_nxt = 11'd0;
        dataTick_nxt = 1'b1;
      end else begin
        dataCnt_nxt = dataCnt_r + 11'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dataCnt_r <= 11'd0;
      dataTick_r <= 1'b0;
    end else begin
      dataCnt_r <= dataCnt_nxt;
      dataTick_r <= dataTick_nxt;
    end
  end

  // Calibration sequencer and data ready; commands during a run are dropped.
  always_comb begin
    calState_nxt = calState_r;
    calCnt_nxt = calCnt_r;
    calTarget_nxt = calTarget_r;
    calKind_nxt = calKind;
    readyN_nxt = dataReadyN;
    unique case (calState_r)
      afc_pkg::CAL_IDLE: begin
        if (calCmdValid && calCmd != afc_pkg::CMD_NONE) begin
          calState_nxt = afc_pkg::CAL_RUN;
          calCnt_nxt = 4'd0;
          calKind_nxt = calCmd;
          calTarget_nxt = calCmd == afc_pkg::CMD_SELFCAL ?
                          `AFC_CAL_BOTH : `AFC_CAL_SINGLE;
          readyN_nxt = 1'b1;
        end else if (dataTick_r) begin
          readyN_nxt = 1'b0;
        end else if (dataReadDone) begin
          readyN_nxt = 1'b1;
        end
      end
      afc_pkg::CAL_RUN: begin
        readyN_nxt = 1'b1;
        if (dataTick_r) begin
          calCnt_nxt = calCnt_r + 4'd1;
          if (calCnt_r + 4'd1 == calTarget_r) begin
            calState_nxt = afc_pkg::CAL_IDLE;
            readyN_nxt = 1'b0;
          end
        end
      end
      default: begin
        calState_nxt = afc_pkg::CAL_IDLE;
        readyN_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      calState_r <= afc_pkg::CAL_IDLE;
      calCnt_r <= 4'd0;
      calTarget_r <= `AFC_CAL_SINGLE;
      calKind <= afc_pkg::CMD_NONE;
      calBusy <= 1'b0;
      dataReadyN <= 1'b1;
    end else begin
      calState_r <= calState_nxt;
      calCnt_r <= calCnt_nxt;
      calTarget_r <= calTarget_nxt;
      calKind <= calKind_nxt;
      calBusy <= calState_nxt == afc_pkg::CAL_RUN;
      dataReadyN <= readyN_nxt;
    end
  end

  // Filter selection; the settling index saturates at the third conversion.
  always_comb begin
    convIdx_nxt = convIdx_r;
    if (settleRestart) begin
      convIdx_nxt = 2'd0;
    end else if (dataTick_r && convIdx_r != 2'd2) begin
      convIdx_nxt = convIdx_r + 2'd1;
    end
    filter_nxt = fltMode;
    if (fltMode == afc_pkg::FLT_AUTO) begin
      unique case (convIdx_nxt)
        2'd0: filter_nxt = afc_pkg::FLT_FAST;
        2'd1: filter_nxt = afc_pkg::FLT_SINC2;
        default: filter_nxt = afc_pkg::FLT_SINC3;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      convIdx_r <= 2'd0;
      filterSel <= afc_pkg::FLT_FAST;
    end else begin
      convIdx_r <= convIdx_nxt;
      filterSel <= filter_nxt;
    end
  end

  // Independent count of data periods inside a calibration.
  logic [4:0] calSeen_r;
  always_ff @(posedge clk) begin
    if (!rst_b || !calBusy) begin
      calSeen_r <= 5'd0;
    end else if (dataTick_r) begin
      calSeen_r <= calSeen_r + 5'd1;
    end
  end

  sequence s_cal_start;
    calCmdValid && calCmd != afc_pkg::CMD_NONE && !calBusy;
  endsequence
  sequence s_settle_change;
    settleRestart && fltMode == afc_pkg::FLT_AUTO;
  endsequence

  AST_TEMP_DIODE: assert property (@(posedge clk) disable iff (!rst_b)
    mux_r == `AFC_TEMP_CODE |=> analog.tempDiode && analog.posSel == 8'h00
      && analog.negSel == 8'h00)
    else $error("Diode code did not open the channels.");
  AST_DIODE_BIAS: assert property (@(posedge clk) disable iff (!rst_b)
    analog.tempDiode |-> analog.src1Anode && analog.cathodeGnd
      && analog.src1Pin)
    else $error("Diode bias path incomplete.");
  AST_CHAN_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    mux_r != `AFC_TEMP_CODE && mux_r[7:4] < 4'h8 |=>
      analog.posSel == 8'h01 << $past(mux_r[7:4]))
    else $error("Positive channel decode wrong.");
  AST_BURNOUT: assert property (@(posedge clk) disable iff (!rst_b)
    ctl_r[`AFC_CTL_BURN] |=> analog.burnSrc == analog.posSel
      && analog.burnSink == analog.negSel)
    else $error("Burnout sources not on selected pair.");
  AST_BUFFER: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 analog.bufferOn == ($past(bufSync_r) && $past(setup_r[1])))
    else $error("Buffer enable is not the AND of pin and bit.");
  AST_CAL_START: assert property (@(posedge clk) disable iff (!rst_b)
    s_cal_start |=> calBusy && dataReadyN && calKind == $past(calCmd))
    else $error("Calibration command not taken.");
  AST_CAL_LEN: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(calBusy) |-> $past(calSeen_r) + 5'd1 ==
      (calKind == afc_pkg::CMD_SELFCAL ? 5'd14 : 5'd7))
    else $error("Calibration length wrong.");
  AST_CAL_DATA_READY_N: assert property (@(posedge clk) disable iff (!rst_b)
    calBusy |-> dataReadyN)
    else $error("Data ready low during calibration.");
  AST_CAL_DONE: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(calBusy) |-> !dataReadyN)
    else $error("Data ready not low at calibration end.");
  AST_READ_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    dataReadDone && !dataTick_r && !calBusy |=> dataReadyN)
    else $error("Data ready not released by read.");
  AST_AUTO_STEP: assert property (@(posedge clk) disable iff (!rst_b)
    s_settle_change |=> filterSel == afc_pkg::FLT_FAST)
    else $error("Auto filter did not restart with fast settling.");

endmodule : afc_frontend

// >>> afc_host_model.sv
`timescale 1ns/1ps
// Host side of the control block. Every strobe it raises is one cycle wide,
// set 1 ns after a rising edge and dropped just after the edge that takes it.
module afc_host_model (
  input wire logic clk,
  input wire logic [7:0] regRdata,
  output afc_pkg::afc_reg_req_s regReq,
  output logic bufferPin,
  output logic calCmdValid,
  output afc_pkg::afc_cmd_e calCmd,
  output logic dataReadDone
);
  // All strobes are idle from time zero so no input floats.
  initial begin
    regReq = '0;
    bufferPin = 1'b0;
    calCmdValid = 1'b0;
    calCmd = afc_pkg::CMD_NONE;
    dataReadDone = 1'b0;
  end

  // Optional write, then a read of the same offset; q is the read data.
  task automatic access(input logic w, input logic [3:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1 regReq = {w, 1'b0, a, d};
    @(posedge clk);
    #1 regReq = {1'b0, 1'b1, a, d};
    @(posedge clk);
    #1 regReq = '0;
    @(posedge clk);
    #1 q = regRdata;
  endtask : access

  // The buffer pin drops before any calibration, because with a reference
  // close to the supply the buffer would spoil the correction values.
  task automatic command(input afc_pkg::afc_cmd_e c);
    @(posedge clk);
    #1 bufferPin = 1'b0;
    calCmdValid = 1'b1;
    calCmd = c;
    @(posedge clk);
    #1 calCmdValid = 1'b0;
  endtask : command

  // One pulse telling the block that the result has been read.
  task automatic readDone;
    @(posedge clk);
    #1 dataReadDone = 1'b1;
    @(posedge clk);
    #1 dataReadDone = 1'b0;
  endtask : readDone

  // Level of the buffer-enable pin.
  task automatic setBuffer(input logic v);
    bufferPin = v;
  endtask : setBuffer
endmodule : afc_host_model

// >>> afc_mod_clock.sv
`timescale 1ns/1ps
`include "afc_defs.svh"
module afc_mod_clock (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic speedSlow,
  output logic modTick
);

  logic [8:0] divCnt_r;
  logic [8:0] divCnt_nxt;
  logic modTick_nxt;
  logic [8:0] gapCnt_r;
  logic gapValid_r;
  logic speedPrev_r;

  // Divider wraps at 128 or 256 oscillator cycles; one-cycle enable out.
  always_comb begin
    logic [8:0] lastCnt;
    lastCnt = speedSlow ? `AFC_DIV_SLOW - 9'd1 : `AFC_DIV_FAST - 9'd1;
    modTick_nxt = 1'b0;
    divCnt_nxt = divCnt_r + 9'd1;
    if (divCnt_r >= lastCnt) begin
      divCnt_nxt = 9'd0;
      modTick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divCnt_r <= 9'd0;
      modTick <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      modTick <= modTick_nxt;
    end
  end

  // Gap between ticks, restarted whenever the speed bit moves.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gapCnt_r <= 9'd0;
      gapValid_r <= 1'b0;
      speedPrev_r <= 1'b0;
    end else begin
      speedPrev_r <= speedSlow;
      if (modTick || speedPrev_r != speedSlow) begin
        gapCnt_r <= 9'd1;
        gapValid_r <= modTick && speedPrev_r == speedSlow;
      end else begin
        gapCnt_r <= gapCnt_r + 9'd1;
      end
    end
  end

  AST_MOD_GAP: assert property (@(posedge clk) disable iff (!rst_b)
    modTick && gapValid_r && $stable(speedSlow) |->
      gapCnt_r == (speedSlow ? `AFC_DIV_SLOW : `AFC_DIV_FAST))
    else $error("Modulator tick spacing does not match speed bit.");

endmodule : afc_mod_clock

// >>> afc_pkg.sv
package afc_pkg;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } afc_cal_state_e;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_SELFCAL = 3'h1,
    CMD_SELFOCAL = 3'h2,
    CMD_SELFGCAL = 3'h3,
    CMD_SYSOCAL = 3'h4,
    CMD_SYSGCAL = 3'h5
  } afc_cmd_e;

  typedef enum logic [1:0] {
    FLT_AUTO = 2'h0,
    FLT_FAST = 2'h1,
    FLT_SINC2 = 2'h2,
    FLT_SINC3 = 2'h3
  } afc_filter_e;

  // One byte access from the command decoder.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } afc_reg_req_s;

  // Analog front-end controls.
  typedef struct packed {
    logic [7:0] posSel;
    logic [7:0] negSel;
    logic [7:0] burnSrc;
    logic [7:0] burnSink;
    logic tempDiode;
    logic src1Anode;
    logic cathodeGnd;
    logic src1Pin;
    logic bufferOn;
    logic [7:0] src1Code;
    logic [1:0] src1Range;
    logic [7:0] src2Code;
    logic [1:0] src2Range;
    logic [2:0] pgaSel;
    logic offsetNeg;
    logic [6:0] offsetMag;
    logic refOn;
    logic refHigh;
  } afc_analog_s;

endpackage : afc_pkg

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int P = 512; // Data period: decimation 4 at divide-by-128.
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic bp;
    logic [7:0] r;
  } afc_row_s;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  afc_pkg::afc_reg_req_s regReq;
  logic [7:0] regRdata, q;
  logic bufferPin, calCmdValid, dataReadDone;
  logic modulatorClock, calBusy, dataReadyN;
  afc_pkg::afc_cmd_e calCmd, calKind, c;
  afc_pkg::afc_analog_s analog;
  afc_pkg::afc_filter_e filterSel;
  logic [7:0] sh [6];
  int n_mismatch = 0;
  int cmp_count = 0;
  int n, k;
  longint t0;
  // Writes with the read-back value they should give; ID bits, DECHI
  // spare bits and unmapped offsets read as zero.
  afc_row_s rows [17] = '{
    '{4'h1, 8'h23, 1'b1, 8'h23}, '{4'h2, 8'h8a, 1'b1, 8'h8a},
    '{4'h0, 8'hea, 1'b1, 8'h0a}, '{4'h0, 8'h0e, 1'b0, 8'h0e},
    '{4'h3, 8'ha5, 1'b0, 8'ha5}, '{4'h4, 8'h3c, 1'b0, 8'h3c},
    '{4'h2, 8'h77, 1'b0, 8'h77}, '{4'h5, 8'h85, 1'b0, 8'h85},
    '{4'h5, 8'h7f, 1'b0, 8'h7f}, '{4'h1, 8'hff, 1'b0, 8'hff},
    '{4'h1, 8'h9a, 1'b0, 8'h9a}, '{4'h2, 8'hf8, 1'b0, 8'hf8},
    '{4'h1, 8'h70, 1'b0, 8'h70}, '{4'hc, 8'h5a, 1'b0, 8'h00},
    '{4'h9, 8'hff, 1'b0, 8'h37}, '{4'h9, 8'h00, 1'b0, 8'h00},
    '{4'h8, 8'h04, 1'b0, 8'h04}};

  afc_frontend i_dut (
    .clk(clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
    .bufferPin(bufferPin), .calCmdValid(calCmdValid), .calCmd(calCmd),
    .dataReadDone(dataReadDone), .analog(analog),
    .modulatorClock(modulatorClock), .filterSel(filterSel),
    .calBusy(calBusy), .calKind(calKind), .dataReadyN(dataReadyN));

  afc_host_model i_host (
    .clk(clk), .regRdata(regRdata), .regReq(regReq),
    .bufferPin(bufferPin), .calCmdValid(calCmdValid), .calCmd(calCmd),
    .dataReadDone(dataReadDone));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic pick(input int s);
    return s == 0 ? modulatorClock : (s == 1 ? dataReadyN : calBusy);
  endfunction : pick

  // Bounded wait for a level; running out of time ends the run at once.
  task automatic waitSig(input int s, input logic v, input int lim,
                         output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1 cnt++;
    end while (pick(s) !== v && cnt < lim);
    if (cnt >= lim) begin
      n_mismatch++;
      final_report();
    end
  endtask : waitSig

  task automatic clearReady;
    i_host.readDone();
    @(posedge clk);
    #1 check(80'(dataReadyN), 80'h1);
  endtask : clearReady

  // Expected analog controls from the shadow registers and the pin.
  function automatic afc_pkg::afc_analog_s expect_analog(input logic bp);
    afc_pkg::afc_analog_s e;
    logic t;
    e = '0;
    t = (sh[1] == 8'hff);
    if (!t && !sh[1][7]) e.posSel = 8'h01 << sh[1][6:4];
    if (!t && !sh[1][3]) e.negSel = 8'h01 << sh[1][2:0];
    e.burnSrc = sh[2][7] ? e.posSel : 8'h00;
    e.burnSink = sh[2][7] ? e.negSel : 8'h00;
    e.tempDiode = t;
    e.src1Anode = t;
    e.cathodeGnd = t;
    e.src1Pin = t | (sh[2][4:3] != 2'h0);
    e.bufferOn = bp & sh[0][1];
    e.src1Code = sh[3];
    e.src1Range = sh[2][4:3];
    e.src2Code = sh[4];
    e.src2Range = sh[2][6:5];
    e.pgaSel = sh[2][2:0];
    {e.offsetNeg, e.offsetMag} = sh[5];
    e.refOn = sh[0][3];
    e.refHigh = sh[0][2];
    return e;
  endfunction : expect_analog

  // Data ready may never fall while a calibration is running.
  always @(negedge clk) begin
    if (calBusy === 1'b1) check(80'(dataReadyN), 80'h1);
  end

  // Main sequence: table first, then timing, calibration, filter, reset.
  initial begin
    sh = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    foreach (rows[i]) begin
      i_host.setBuffer(rows[i].bp);
      i_host.access(1'b1, rows[i].a, rows[i].d, q);
      if (rows[i].a < 4'h6) sh[rows[i].a[2:0]] = rows[i].d;
      check(80'(q), 80'(rows[i].r));
      check(80'(analog),
            80'(expect_analog(rows[i].bp)));
    end
    for (int s = 0; s < 2; s++) begin
      i_host.access(1'b1, 4'h0, {3'h0, s[0], 4'h0}, q);
      waitSig(0, 1'b1, 600, n);
      waitSig(0, 1'b1, 600, n);
      check(80'(n), s ? 80'd256 : 80'd128);
    end
    // Low gain and decimation 4 before calibrating, as a host should.
    i_host.access(1'b1, 4'h0, 8'h00, q);
    i_host.access(1'b1, 4'h2, 8'h00, q);
    i_host.command(afc_pkg::CMD_NONE);
    check(80'(calBusy), 80'h0);
    for (int i = 1; i < 6; i++) begin
      c = afc_pkg::afc_cmd_e'(i);
      k = (i == 1) ? 14 : 7;
      i_host.command(c);
      t0 = $time;
      check(80'({calBusy, dataReadyN, calKind}), 80'({2'b11, c}));
      i_host.command(i == 1 ? afc_pkg::CMD_SYSOCAL : afc_pkg::CMD_SELFCAL);
      i_host.readDone();
      check(80'(calKind), 80'(c));
      waitSig(2, 1'b0, 15 * P, n);
      n = int'(($time - t0) / 4);
      check(80'(n > (k - 1) * P && n <= k * P + 2), 80'h1);
      check(80'(dataReadyN), 80'h0);
      clearReady();
    end
    // The auto filter steps one result at a time after a channel change.
    waitSig(1, 1'b0, P + 8, n);
    clearReady();
    i_host.access(1'b1, 4'h1, 8'h45, q);
    check(80'(filterSel), 80'(afc_pkg::FLT_FAST));
    for (int j = 2; j < 5; j++) begin
      waitSig(1, 1'b0, P + 8, n);
      @(posedge clk);
      #1 check(80'(filterSel), j == 2 ? 80'h2 : 80'h3);
      clearReady();
    end
    i_host.access(1'b1, 4'h2, 8'h03, q);
    check(80'(filterSel), 80'(afc_pkg::FLT_FAST));
    for (int m = 1; m < 4; m++) begin
      i_host.access(1'b1, 4'h9, 8'(m << 4), q);
      check(80'(filterSel), 80'(m));
    end
    // A second reset in mid-run brings back every reset value.
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (3) @(posedge clk);
    #1 check(80'({calBusy, dataReadyN, calKind, filterSel}),
             80'({2'b01, afc_pkg::CMD_NONE, afc_pkg::FLT_FAST}));
    rst_b = 1'b1;
    sh = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    // Status after reset: fast filter, no calibration, data ready high.
    for (int r = 0; r < 12; r++) begin
      i_host.access(1'b0, 4'(r), 8'h00, q);
      k = (r == 8) ? 'h80 : ((r == 9) ? 'h01 : ((r == 11) ? 'h09 : 0));
      if (r < 6) k = int'(sh[r]);
      check(80'(q), 80'(k));
    end
    check(80'(analog), 80'(expect_analog(bufferPin)));
    final_report();
  end
endmodule : testbench
